//--- design/iod_addr_map.sv
// translation of a core access onto the data-space address of the i/o registers
`timescale 1ns/1ps
module iod_addr_map (
    // access from the core
    input wire iod_pkg::iod_op_t op_i,
    input wire logic [7:0] addr_i,
    // decoded result
    output logic [7:0] data_addr_o,
    output logic legal_o,
    output logic impl_o
);

    // -------------------------------------------------------------
    // map and range checks
    // -------------------------------------------------------------
    // port and bit forms carry an i/o address, memory forms a data address
    always_comb begin
        data_addr_o = addr_i;
        legal_o = 1'b0;
        unique case (op_i)
            iod_pkg::IOD_PORT_READ, iod_pkg::IOD_PORT_WRITE: begin
                data_addr_o = addr_i + iod_pkg::IOD_DATA_OFFSET;
                legal_o = (addr_i <= iod_pkg::IOD_PORT_IO_LAST);
            end
            iod_pkg::IOD_BIT_SET, iod_pkg::IOD_BIT_CLEAR,
            iod_pkg::IOD_SKIP_SET, iod_pkg::IOD_SKIP_CLEAR: begin
                data_addr_o = addr_i + iod_pkg::IOD_DATA_OFFSET;
                legal_o = (addr_i <= iod_pkg::IOD_BIT_IO_LAST);
            end
            iod_pkg::IOD_MEM_READ, iod_pkg::IOD_MEM_WRITE: begin
                // the working registers below 0x20 are not this block's
                legal_o = (addr_i >= iod_pkg::IOD_DATA_OFFSET);
            end
        endcase
    end

    // reserved tail of the extended space holds no register
    assign impl_o = (data_addr_o <= iod_pkg::IOD_IMPL_LAST);

endmodule : iod_addr_map

//--- design/iod_io_space.sv
// i/o register space of the core: storage, bit access, flag clearing, decode
//
// What this block does
// - I/O addresses 0x00 to 0x1F allow single-bit set, clear and test-and-skip.
// - Single-bit set or clear changes only the addressed bit, never others.
// - Status flags clear when one is written, unless an event sets them in that cycle; writing zero leaves them.
// - Port read and write reach only I/O locations 0x00 to 0x3F.
// - Data-space access reaches an I/O register at its address plus 0x20.
// - Extended locations 0x60 to 0xFF are reached only by memory load and store.
`timescale 1ns/1ps
module iod_io_space (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // access from the core
    input wire logic req_i,
    input wire iod_pkg::iod_op_t op_i,
    input wire logic [7:0] addr_i,
    input wire logic [2:0] bit_i,
    input wire logic [7:0] wdata_i,
    // hardware events that raise status flags
    input wire logic [7:0] flag_event_i,
    // answer to the core
    output logic rvalid_o,
    output logic [7:0] rdata_o,
    output logic skip_o,
    output logic err_o,
    // current status flags
    output logic [7:0] flag_o
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] bit_mask(input logic [2:0] pos);
        bit_mask = 8'h01 << pos;
    endfunction : bit_mask

    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    logic [7:0] data_addr;
    logic legal;
    logic impl;
    logic [7:0] loc_idx;
    logic acc;
    logic wr_en;
    logic [7:0] wr_mask;
    logic [7:0] wr_val;
    logic [7:0] cur_val;
    logic [7:0] store_q [iod_pkg::IOD_NUM_LOC];

    iod_addr_map u_map (
        .op_i(op_i),
        .addr_i(addr_i),
        .data_addr_o(data_addr),
        .legal_o(legal),
        .impl_o(impl)
    );

    assign acc = req_i && legal && impl;
    assign loc_idx = data_addr - iod_pkg::IOD_DATA_OFFSET;
    assign cur_val = acc ? store_q[loc_idx] : 8'h00;

    // write strobe and per-bit mask; bit forms touch one bit only
    always_comb begin
        wr_en = 1'b0;
        wr_mask = 8'h00;
        wr_val = 8'h00;
        if (acc) begin
            unique case (op_i)
                iod_pkg::IOD_PORT_WRITE, iod_pkg::IOD_MEM_WRITE: begin
                    wr_en = 1'b1;
                    wr_mask = 8'hFF;
                    wr_val = wdata_i;
                end
                iod_pkg::IOD_BIT_SET: begin
                    wr_en = 1'b1;
                    wr_mask = bit_mask(bit_i);
                    wr_val = 8'hFF;
                end
                iod_pkg::IOD_BIT_CLEAR: begin
                    wr_en = 1'b1;
                    wr_mask = bit_mask(bit_i);
                    wr_val = 8'h00;
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    // one process per location; the flag location clears on written ones
    // and a hardware event in the same cycle wins over the clear
    for (genvar g = 0; g < iod_pkg::IOD_NUM_LOC; g++) begin : g_loc
        localparam logic [7:0] LOC = 8'(g);
        localparam logic IS_FLAG =
            (LOC == (iod_pkg::IOD_FLAG_DATA_ADDR - iod_pkg::IOD_DATA_OFFSET));
        always_ff @(posedge clk_i) begin
            if (reset_i) begin
                store_q[g] <= IS_FLAG ? iod_pkg::IOD_FLAG_RESET : iod_pkg::IOD_LOC_RESET;
            end else if (IS_FLAG) begin
                if (wr_en && loc_idx == LOC) begin
                    store_q[g] <= (store_q[g] & ~(wr_mask & wr_val)) | flag_event_i;
                end else begin
                    store_q[g] <= store_q[g] | flag_event_i;
                end
            end else if (wr_en && loc_idx == LOC) begin
                store_q[g] <= (store_q[g] & ~wr_mask) | (wr_val & wr_mask);
            end
        end
    end

    assign flag_o = store_q[iod_pkg::IOD_FLAG_DATA_ADDR - iod_pkg::IOD_DATA_OFFSET];

    // -------------------------------------------------------------
    // answer
    // -------------------------------------------------------------
    // every request is answered one cycle later, refused or not
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rvalid_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            rvalid_o <= req_i;
            err_o <= req_i && !legal;
        end
    end

    // read data and skip decision; reserved space reads as zero
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
            skip_o <= 1'b0;
        end else begin
            rdata_o <= cur_val;
            skip_o <= 1'b0;
            if (acc && op_i == iod_pkg::IOD_SKIP_SET) begin
                skip_o <= cur_val[bit_i];
            end else if (acc && op_i == iod_pkg::IOD_SKIP_CLEAR) begin
                skip_o <= !cur_val[bit_i];
            end
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    logic [7:0] past_idx;
    always_ff @(posedge clk_i) begin
        past_idx <= loc_idx;
    end

    property p_bit_range;
        @(posedge clk_i) disable iff (reset_i)
        (req_i && op_i inside {iod_pkg::IOD_BIT_SET, iod_pkg::IOD_SKIP_SET}
            && addr_i > iod_pkg::IOD_BIT_IO_LAST) |=> (err_o && rvalid_o && !skip_o);
    endproperty
    a_bit_range: assert property (p_bit_range) else $error("bit op out of range");

    property p_bit_only;
        @(posedge clk_i) disable iff (reset_i)
        (acc && op_i == iod_pkg::IOD_BIT_CLEAR && loc_idx != 8'h16 && bit_i == 3'h0)
            |=> ((store_q[past_idx] & 8'hFE) == ($past(cur_val) & 8'hFE))
                && !store_q[past_idx][0];
    endproperty
    a_bit_only: assert property (p_bit_only) else $error("bit clear hit other bits");

    property p_flag_zero_keeps;
        @(posedge clk_i) disable iff (reset_i)
        (acc && data_addr == iod_pkg::IOD_FLAG_DATA_ADDR && wr_en && wr_val == 8'h00)
            |=> ((flag_o & $past(flag_o)) == $past(flag_o));
    endproperty
    a_flag_zero_keeps: assert property (p_flag_zero_keeps) else $error("flag lost");

    property p_flag_clear;
        @(posedge clk_i) disable iff (reset_i)
        (acc && op_i == iod_pkg::IOD_MEM_WRITE && data_addr == iod_pkg::IOD_FLAG_DATA_ADDR
            && wdata_i == 8'hFF && flag_event_i == 8'h00) |=> (flag_o == 8'h00);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    // a hardware event always lands, even against a clear in the same cycle
    property p_flag_set_wins;
        @(posedge clk_i) disable iff (reset_i)
        (flag_event_i != 8'h00) |=> ((flag_o & $past(flag_event_i)) == $past(flag_event_i));
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag event lost");

    property p_port_range;
        @(posedge clk_i) disable iff (reset_i)
        (req_i && op_i inside {iod_pkg::IOD_PORT_READ, iod_pkg::IOD_PORT_WRITE})
            |-> (legal == (addr_i <= 8'h3F)) ##1 (err_o == !$past(legal));
    endproperty
    a_port_range: assert property (p_port_range) else $error("port range wrong");

    property p_port_map;
        @(posedge clk_i) disable iff (reset_i)
        (req_i && op_i == iod_pkg::IOD_PORT_READ && legal)
            |-> (data_addr == addr_i + 8'h20) ##1 (rdata_o == store_q[past_idx]);
    endproperty
    a_port_map: assert property (p_port_map) else $error("port map offset wrong");

    property p_ext_mem_only;
        @(posedge clk_i) disable iff (reset_i)
        (req_i && legal && data_addr >= iod_pkg::IOD_EXT_FIRST)
            |-> op_i inside {iod_pkg::IOD_MEM_READ, iod_pkg::IOD_MEM_WRITE};
    endproperty
    a_ext_mem_only: assert property (p_ext_mem_only) else $error("extended via port");

    property p_rsvd_zero;
        @(posedge clk_i) disable iff (reset_i)
        (req_i && op_i == iod_pkg::IOD_MEM_READ && addr_i >= iod_pkg::IOD_RSVD_FIRST)
            |=> (rvalid_o && rdata_o == 8'h00 && !err_o);
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved read not zero");

    c_skip: cover property (@(posedge clk_i) disable iff (reset_i) skip_o);
    c_flag_clear: cover property (@(posedge clk_i) disable iff (reset_i)
        $fell(flag_o != 8'h00));
    c_ext_write: cover property (@(posedge clk_i) disable iff (reset_i)
        acc && op_i == iod_pkg::IOD_MEM_WRITE && data_addr >= iod_pkg::IOD_EXT_FIRST);
    c_err: cover property (@(posedge clk_i) disable iff (reset_i) err_o);

endmodule : iod_io_space

//--- design/iod_pkg.sv
// shared constants and types for the i/o space address decoder
package iod_pkg;

    // -------------------------------------------------------------
    // access kinds issued by the core
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        IOD_PORT_READ = 3'b000,
        IOD_PORT_WRITE = 3'b001,
        IOD_BIT_SET = 3'b010, // io_bit_set_op
        IOD_BIT_CLEAR = 3'b011, // io_bit_clear_op
        IOD_SKIP_SET = 3'b100, // skip_if_io_bit_set
        IOD_SKIP_CLEAR = 3'b101, // skip_if_io_bit_clear
        IOD_MEM_READ = 3'b110, // memory_read_op and its direct/displaced forms
        IOD_MEM_WRITE = 3'b111 // memory_write_op and its direct/displaced forms
    } iod_op_t;

    // -------------------------------------------------------------
    // address map
    // -------------------------------------------------------------
    localparam logic [7:0] IOD_BIT_IO_LAST = 8'h1F;
    localparam logic [7:0] IOD_PORT_IO_LAST = 8'h3F;
    localparam logic [7:0] IOD_DATA_OFFSET = 8'h20;
    localparam logic [7:0] IOD_EXT_FIRST = 8'h60;
    localparam logic [7:0] IOD_IMPL_LAST = 8'hD9;
    localparam logic [7:0] IOD_RSVD_FIRST = 8'hDA;
    localparam int IOD_NUM_LOC = 186; // data 0x20 .. 0xD9

    // status register with write-one-to-clear flags, i/o address
    localparam logic [7:0] IOD_FLAG_IO_ADDR = 8'h16;
    localparam logic [7:0] IOD_FLAG_DATA_ADDR = 8'h36;
    localparam logic [7:0] IOD_FLAG_RESET = 8'h00;
    localparam logic [7:0] IOD_LOC_RESET = 8'h00;

endpackage : iod_pkg

//--- verif/io_space_address_decode_bench.sv
// self-checking bench of the i/o space decoder
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module io_space_address_decode_bench;
    logic clk_i, reset_i, req_i, req_q, rvalid_o, skip_o, err_o;
    iod_pkg::iod_op_t op_i;
    logic [7:0] addr_i, wdata_i, flag_event_i, rdata_o, flag_o, flags;
    logic [2:0] bit_i;
    logic [7:0] mem [256];
    logic [10:0] expq [$];
    logic [10:0] e;
    logic [15:0] lfsr = 16'h2D5A;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    iod_io_space i_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .op_i(op_i),
        .addr_i(addr_i), .bit_i(bit_i), .wdata_i(wdata_i), .flag_event_i(flag_event_i),
        .rvalid_o(rvalid_o), .rdata_o(rdata_o), .skip_o(skip_o), .err_o(err_o),
        .flag_o(flag_o));
    iod_core_model i_core (.clk_i(clk_i), .req_o(req_i), .op_o(op_i), .addr_o(addr_i),
        .bit_o(bit_i), .wdata_o(wdata_i));
    // ----
    // clock, watchdog and answer checker
    // ----
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        req_q <= req_i;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    // sampled on the falling edge so registered answers have settled
    always @(negedge clk_i) begin
        if (!reset_i) `CHK(rvalid_o, req_q)
        if (rvalid_o === 1'b1) begin
            e = expq.pop_front();
            `CHK(err_o, e[9])
            `CHK(skip_o, e[8])
            if (e[10]) `CHK(rdata_o, e[7:0])
        end
    end
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    // op codes: 0 port rd, 1 port wr, 2 bit set, 3 bit clr, 4/5 skip set/clr, 6/7 mem rd/wr
    task automatic acc(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
            input logic [7:0] w);
        logic [7:0] da;
        logic [7:0] v;
        logic ok;
        da = (op[2:1] == 2'b11) ? a : a + iod_pkg::IOD_DATA_OFFSET;
        case (op)
            3'h0, 3'h1: ok = (a <= iod_pkg::IOD_PORT_IO_LAST);
            3'h6, 3'h7: ok = (a >= iod_pkg::IOD_DATA_OFFSET);
            default: ok = (a <= iod_pkg::IOD_BIT_IO_LAST);
        endcase
        v = (da == iod_pkg::IOD_FLAG_DATA_ADDR) ? flags : (da > iod_pkg::IOD_IMPL_LAST) ?
            8'h00 : mem[da];
        expq.push_back({!ok || op inside {3'h0, 3'h4, 3'h5, 3'h6}, !ok,
            ok && ((op == 3'h4 && v[b]) || (op == 3'h5 && !v[b])), ok ? v : 8'h00});
        if (ok && da == iod_pkg::IOD_FLAG_DATA_ADDR) begin
            if (op == 3'h1 || op == 3'h7) flags = flags & ~w;
            if (op == 3'h2) flags[b] = 1'b0;
        end else if (ok && da <= iod_pkg::IOD_IMPL_LAST) begin
            // every modelled bit is stored, so no write carries a reserved bit
            if (op == 3'h1 || op == 3'h7) mem[da] = w;
            if (op == 3'h2 || op == 3'h3) mem[da][b] = !op[0];
        end
        i_core.access(op, a, b, w);
    endtask : acc
    // one step of the random source
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic pulse(input logic [7:0] ev);
        i_core.idle();
        flag_event_i = ev;
        flags = flags | ev;
        @(posedge clk_i);
        #1;
        flag_event_i = 8'h00;
    endtask : pulse
    // ----
    // scenarios
    // ----
    initial begin
        reset_i = 1'b1;
        flag_event_i = 8'h00;
        flags = 8'h00;
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (8) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        // walk, then each edge of the address ranges
        acc(3'h1, 8'h05, 3'h0, 8'hA5);
        acc(3'h6, 8'h25, 3'h0, 8'h00);
        acc(3'h4, 8'h05, 3'h0, 8'h00);
        acc(3'h1, 8'h3F, 3'h0, 8'h3C);
        acc(3'h6, 8'h5F, 3'h0, 8'h00);
        acc(3'h0, 8'h40, 3'h0, 8'h00);
        acc(3'h2, 8'h1F, 3'h7, 8'h00);
        acc(3'h2, 8'h20, 3'h7, 8'h00);
        acc(3'h6, 8'h1F, 3'h0, 8'h00);
        acc(3'h7, 8'h60, 3'h0, 8'h96);
        acc(3'h7, 8'hD9, 3'h0, 8'h69);
        acc(3'h1, 8'h60, 3'h0, 8'h11);
        acc(3'h6, 8'h60, 3'h0, 8'h00);
        acc(3'h6, 8'hD9, 3'h0, 8'h00);
        $display("test ranges done");
        // flags: bit access and write-one-to-clear leave the other flags alone
        pulse(8'hFF);
        acc(3'h2, 8'h16, 3'h3, 8'h00);
        acc(3'h3, 8'h16, 3'h5, 8'h00);
        acc(3'h1, 8'h16, 3'h0, 8'h05);
        acc(3'h1, 8'h16, 3'h0, 8'h00);
        acc(3'h7, 8'h36, 3'h0, 8'h80);
        acc(3'h4, 8'h16, 3'h1, 8'h00);
        acc(3'h5, 8'h16, 3'h3, 8'h00);
        acc(3'h0, 8'h16, 3'h0, 8'h00);
        acc(3'h7, 8'h36, 3'h0, 8'hFF);
        i_core.idle();
        `CHK(flag_o, flags)
        $display("test flags done");
        // reserved places are never written; the last real location is, and reads back
        acc(3'h7, 8'hD9, 3'h0, 8'hFF);
        acc(3'h6, 8'hD9, 3'h0, 8'h00);
        acc(3'h6, 8'hDA, 3'h0, 8'h00);
        acc(3'h6, 8'hFF, 3'h0, 8'h00);
        acc(3'h6, 8'hD9, 3'h0, 8'h00);
        $display("test reserved done");
        // every bit of one register, neighbours preloaded
        acc(3'h1, 8'h0A, 3'h0, 8'h5A);
        for (int b = 0; b < 8; b++) begin
            for (int k = 2; k < 6; k++) acc(k[2:0], 8'h0A, b[2:0], 8'h00);
        end
        acc(3'h0, 8'h0A, 3'h0, 8'h00);
        $display("test bits done");
        // random traffic; reserved writes are turned into reads
        repeat (400) begin
            lfsr = lfsr_next(lfsr);
            if (lfsr[2:0] == 3'h7 && lfsr[15:8] >= iod_pkg::IOD_RSVD_FIRST) begin
                lfsr[0] = 1'b0;
            end
            acc(lfsr[2:0], lfsr[14] ? lfsr[15:8] : {3'h0, lfsr[12:8]}, lfsr[5:3],
                lfsr[7:0] ^ lfsr[15:8]);
        end
        i_core.idle();
        i_core.idle();
        `CHK(expq.size(), 0)
        $display("test random done");
        final_report();
    end
endmodule : io_space_address_decode_bench

//--- verif/iod_core_model.sv
// behavioural model of the core that issues accesses to the i/o space
`timescale 1ns/1ps
module iod_core_model (
    // clock
    input wire logic clk_i,
    // access towards the decoder
    output logic req_o,
    output iod_pkg::iod_op_t op_o,
    output logic [7:0] addr_o,
    output logic [2:0] bit_o,
    output logic [7:0] wdata_o
);
    // ----
    // bus driving
    // ----
    initial begin
        req_o = 1'b0;
        op_o = iod_pkg::IOD_PORT_READ;
        addr_o = 8'h00;
        bit_o = 3'h0;
        wdata_o = 8'h00;
    end
    // one access per edge; req stays up so that calls chain back to back
    task automatic access(input logic [2:0] op, input logic [7:0] a, input logic [2:0] b,
            input logic [7:0] w);
        @(posedge clk_i);
        #1;
        req_o = 1'b1;
        op_o = iod_pkg::iod_op_t'(op);
        addr_o = a;
        bit_o = b;
        wdata_o = w;
    endtask : access
    // released address, bit and data lines go inverted so a stale value is never read as live
    task automatic idle();
        @(posedge clk_i);
        #1;
        req_o = 1'b0;
        addr_o = ~addr_o;
        bit_o = ~bit_o;
        wdata_o = ~wdata_o;
    endtask : idle
endmodule : iod_core_model
